// >>> core/ppt_pkg.sv
// Purpose: constants and types for the 1pps placement and time-tag block
// Assumes: 50 MHz system clock, APB register access
// Notes: offsets are byte addresses of aligned 32-bit words
package ppt_pkg;
	// clock and time base
	localparam int unsigned CLK_HZ        = 50_000_000;
	localparam int unsigned CLK_NS        = 1_000_000_000 / CLK_HZ;
	localparam int unsigned SEC_NS        = 1_000_000_000;
	localparam int unsigned FINE_CLK_HZ   = 2_500_000;
	localparam int unsigned FINE_DIV      = CLK_HZ / FINE_CLK_HZ;
	localparam int unsigned OUT_FINE_NS   = 100;
	localparam int unsigned PULSE_W_US    = 10;
	localparam int unsigned PULSE_W_CYC   = (PULSE_W_US * 1000) / CLK_NS;
	localparam int unsigned MOD_STEPS     = 24;
	// parameter limits and reset values
	localparam logic [14:0] TS_MIN        = 15'h1B58;
	localparam logic [14:0] TS_MAX        = 15'h61A8;
	localparam logic [14:0] TS_RST        = 15'h3333;
	localparam int          TO_MIN        = -32767;
	localparam int          TO_MAX        = 32768;
	localparam logic [16:0] TO_RST        = 17'h00000;
	localparam logic [7:0]  PS_MIN        = 8'h64;
	localparam logic [7:0]  PS_MAX        = 8'hFF;
	localparam logic [7:0]  PS_RST        = 8'hC8;
	localparam logic [11:0] FO_RST        = 12'h000;
	localparam int          FO_LIM        = 2000;
	localparam logic [31:0] TAG_NONE      = 32'hFFFFFFFF;
	// register map
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_TAG    = 8'h04;
	localparam logic [7:0] A_TS     = 8'h08;
	localparam logic [7:0] A_TO     = 8'h0C;
	localparam logic [7:0] A_PS     = 8'h10;
	localparam logic [7:0] A_PP     = 8'h14;
	localparam logic [7:0] A_NV_TS  = 8'h18;
	localparam logic [7:0] A_NV_TO  = 8'h1C;
	localparam logic [7:0] A_NV_PS  = 8'h20;
	localparam logic [7:0] A_POS    = 8'h24;
	localparam logic [7:0] A_FO     = 8'h28;
	localparam logic [7:0] A_STAT   = 8'h2C;
	// control register bit positions
	localparam int C_ST_TS   = 0;
	localparam int C_ST_TO   = 1;
	localparam int C_ST_PS   = 2;
	localparam int C_RESTART = 3;
	localparam int C_PLL     = 4;
	// output placement split into counted and analog parts
	typedef struct packed {
		logic [29:0] coarse;
		logic [6:0]  fine;
	} ppt_place_t;
	typedef enum logic [4:0] {
		TT_IDLE = 5'b00001,
		TT_WAIT = 5'b00010,
		TT_STR  = 5'b00100,
		TT_CALC = 5'b01000,
		TT_NORM = 5'b10000
	} ppt_tt_t;
endpackage

// >>> core/ppt_core.sv
// Purpose: 1pps output placement and 1pps input time-tagging, APB slave
// Assumes: external pulse stretcher and 8-bit delay DAC around this logic
// Notes: Notes on behaviour below
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module ppt_core
	import ppt_pkg::*;
#(
	parameter int unsigned SEC_LEN = SEC_NS
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        pps_in,
	input  wire logic        stretch_in,
	output logic             pps_out,
	output logic      [7:0]  fine_delay_dac_code
);
	localparam logic [33:0] SEC34 = 34'(SEC_LEN);

	// pin synchronisers, three stages each
	logic [2:0] pin_s, next_pin_s;
	logic [2:0] str_s, next_str_s;
	logic       pin_lvl, next_pin_lvl;
	logic       str_lvl, next_str_lvl;

	// time base and placement
	logic [29:0] ns_now, next_ns_now;
	logic [4:0]  div, next_div;
	logic [29:0] pos, next_pos;
	logic [29:0] mod_r, next_mod_r;
	logic [4:0]  mod_k, next_mod_k;
	logic        busy, next_busy;
	ppt_place_t  plc, next_plc;
	logic [8:0]  pw_cnt, next_pw_cnt;
	logic        pps_q, next_pps_q;
	logic [7:0]  dac, next_dac;

	// parameters in use and stored copies
	logic [14:0] ts, next_ts, nv_ts, next_nv_ts;
	logic [16:0] to, next_to, nv_to, next_nv_to;
	logic [7:0]  ps, next_ps, nv_ps, next_nv_ps;
	logic        pll_en, next_pll_en;
	logic [11:0] fo, next_fo;

	// time-tag machine
	ppt_tt_t     tst, next_tst;
	logic [29:0] edge_ns, next_edge_ns;
	logic [15:0] cnt, next_cnt;
	logic        seen, next_seen;
	logic signed [33:0] s, next_s;
	logic [29:0] tag, next_tag;
	logic        tag_ok, next_tag_ok;
	logic        done;

	logic        wr, rd, hit;
	logic        pin_rise, fine_tick, fire;
	logic [30:0] fine_prod;
	logic [25:0] dac_prod;
	logic signed [33:0] err, fo_w;

	assign wr        = psel & penable & pwrite;
	assign rd        = psel & penable & ~pwrite;
	assign pready    = 1'b1;
	assign pps_out   = pps_q;
	assign fine_delay_dac_code = dac;
	assign pin_rise  = next_pin_lvl & ~pin_lvl;
	assign fine_tick = (div == 5'h00);
	assign fire      = ~busy & (ns_now == plc.coarse);
	assign fine_prod = 31'(cnt) * 31'(ts);
	// scale remainder by pulse slope, about 1/100
	assign dac_prod  = 26'(plc.fine) * 26'(ps) * 26'h51F;

	// address decode
	always_comb begin
		unique case (paddr)
			A_CTRL, A_TAG, A_TS, A_TO, A_PS, A_PP, A_NV_TS, A_NV_TO, A_NV_PS,
			A_POS, A_FO, A_STAT: hit = 1'b1;
			default:             hit = 1'b0;
		endcase
	end

	// read mux and error answer
	always_comb begin
		prdata  = 32'h00000000;
		pslverr = psel & penable & (~hit | (pwrite & (paddr == A_PP) & busy));
		if (rd) begin
			unique case (paddr)
				A_TAG:   prdata = tag_ok ? {2'h0, tag} : TAG_NONE;
				A_TS:    prdata = {17'h00000, ts};
				A_TO:    prdata = {{15{to[16]}}, to};
				A_PS:    prdata = {24'h000000, ps};
				A_NV_TS: prdata = {17'h00000, nv_ts};
				A_NV_TO: prdata = {{15{nv_to[16]}}, nv_to};
				A_NV_PS: prdata = {24'h000000, nv_ps};
				A_POS:   prdata = {2'h0, pos};
				A_FO:    prdata = {{20{fo[11]}}, fo};
				A_CTRL:  prdata = {27'h0000000, pll_en, 4'h0};
				A_STAT:  prdata = {29'h00000000, pll_en, busy, tag_ok};
				default: prdata = 32'h00000000;
			endcase
		end
	end

	// input rise once second and third stages agree
	always_comb begin
		next_pin_s   = {pin_s[1:0], pps_in};
		next_str_s   = {str_s[1:0], stretch_in};
		next_pin_lvl = (pin_s[2] == pin_s[1]) ? pin_s[2] : pin_lvl;
		next_str_lvl = (str_s[2] == str_s[1]) ? str_s[2] : str_lvl;
	end

	// main next-state logic
	always_comb begin
		next_ns_now  = (ns_now + 30'(CLK_NS) >= 30'(SEC_LEN)) ? 30'h0 : ns_now + 30'(CLK_NS);
		next_div     = (div == 5'(FINE_DIV - 1)) ? 5'h00 : div + 5'h01;
		next_pos     = pos;
		next_mod_r   = mod_r;
		next_mod_k   = mod_k;
		next_busy    = busy;
		next_plc     = plc;
		next_pw_cnt  = pw_cnt;
		next_pps_q   = pps_q;
		next_dac     = dac;
		next_ts      = ts;
		next_to      = to;
		next_ps      = ps;
		next_nv_ts   = nv_ts;
		next_nv_to   = nv_to;
		next_nv_ps   = nv_ps;
		next_pll_en  = pll_en;
		next_fo      = fo;
		next_tst     = tst;
		next_edge_ns = edge_ns;
		next_cnt     = cnt;
		next_seen    = seen;
		next_s       = s;
		next_tag     = tag;
		done         = 1'b0;
		err          = 34'sh0;
		fo_w         = 34'sh0;
		// output fires at counted part, DAC adds the rest
		if (fire) begin
			next_pps_q  = 1'b1;
			next_pw_cnt = 9'(PULSE_W_CYC - 1);
		end else if (pps_q) begin
			next_pps_q  = (pw_cnt != 9'h000);
			next_pw_cnt = pw_cnt - 9'h001;
		end
		// split position into 100 ns grid and remainder
		if (busy) begin
			if (mod_r >= (30'(OUT_FINE_NS) << mod_k))
				next_mod_r = mod_r - (30'(OUT_FINE_NS) << mod_k);
			next_mod_k = mod_k - 5'h01;
			if (mod_k == 5'h00) begin
				next_busy  = 1'b0;
				next_plc   = '{coarse: pos - next_mod_r, fine: 7'(next_mod_r)};
			end
		end else begin
			next_dac = dac_prod[24:17];
		end
		// register writes
		if (wr) begin
			unique case (paddr)
				A_CTRL: begin
					next_pll_en = pwdata[C_PLL];
					if (pwdata[C_ST_TS]) next_nv_ts = ts;
					if (pwdata[C_ST_TO]) next_nv_to = to;
					if (pwdata[C_ST_PS]) next_nv_ps = ps;
					if (pwdata[C_RESTART]) begin
						next_ts = nv_ts;
						next_to = nv_to;
						next_ps = nv_ps;
					end
				end
				A_TS: if (pwdata[31:15] == 17'h0 && pwdata[14:0] >= TS_MIN &&
					pwdata[14:0] <= TS_MAX) next_ts = pwdata[14:0];
				A_TO: if (signed'(pwdata) >= TO_MIN && signed'(pwdata) <= TO_MAX)
					next_to = pwdata[16:0];
				// pulse slope accepted only in range
				A_PS: if (pwdata[31:8] == 24'h0 && pwdata[7:0] >= PS_MIN)
					next_ps = pwdata[7:0];
				// move earlier, wrap within the second
				A_PP: if (~busy && pwdata < SEC_LEN) begin
					next_pos   = (pos >= pwdata[29:0]) ? pos - pwdata[29:0] :
						pos + 30'(SEC_LEN) - pwdata[29:0];
					next_mod_r = next_pos;
					next_mod_k = 5'(MOD_STEPS - 1);
					next_busy  = 1'b1;
				end
				default: ;
			endcase
		end
		// time-tag sequence
		unique case (tst)
			TT_IDLE: if (pin_rise) next_tst = TT_WAIT;
			// coarse stamp at next 2.5 MHz edge
			TT_WAIT: if (fine_tick) begin
				next_edge_ns = ns_now;
				next_cnt     = 16'h0000;
				next_seen    = 1'b0;
				next_tst     = TT_STR;
			end
			// count stretched pulse at 2.5 MHz
			TT_STR: begin
				if (str_lvl & fine_tick) begin
					next_cnt  = cnt + 16'h0001;
					next_seen = 1'b1;
				end
				if (seen & ~str_lvl) next_tst = TT_CALC;
			end
			// add offset; refer to output position
			TT_CALC: begin
				next_s   = 34'(edge_ns) - 34'(fine_prod[30:16]) - 34'(pos) +
					34'(signed'(to));
				next_tst = TT_NORM;
			end
			TT_NORM: begin
				if (s < 0)
					next_s = s + signed'(SEC34);
				else if (s >= signed'(SEC34))
					next_s = s - signed'(SEC34);
				else begin
					done     = 1'b1;
					next_tag = 30'(s);
					next_tst = TT_IDLE;
				end
			end
			default: next_tst = TT_IDLE;
		endcase
		// steer frequency offset from signed tag
		if (done && pll_en) begin
			err  = (s >= signed'(SEC34 >> 1)) ? s - signed'(SEC34) : s;
			fo_w = 34'(signed'(fo)) - (err >>> 2);
			if (fo_w > FO_LIM) fo_w = 34'(FO_LIM);
			if (fo_w < -FO_LIM) fo_w = -34'(FO_LIM);
			next_fo = 12'(fo_w);
		end
	end

	// fresh tag per input pulse; read clears, new result wins
	assign next_tag_ok = done | (tag_ok & ~(rd & (paddr == A_TAG)));

	// synchroniser registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s   <= 3'h0;
			str_s   <= 3'h0;
			pin_lvl <= 1'b0;
			str_lvl <= 1'b0;
		end else begin
			pin_s   <= next_pin_s;
			str_s   <= next_str_s;
			pin_lvl <= next_pin_lvl;
			str_lvl <= next_str_lvl;
		end
	end

	// state registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ns_now  <= 30'h0;
			div     <= 5'h00;
			pos     <= 30'h0;
			mod_r   <= 30'h0;
			mod_k   <= 5'h00;
			busy    <= 1'b0;
			plc     <= '0;
			pw_cnt  <= 9'h000;
			pps_q   <= 1'b0;
			dac     <= 8'h00;
			ts      <= TS_RST;
			to      <= TO_RST;
			ps      <= PS_RST;
			nv_ts   <= TS_RST;
			nv_to   <= TO_RST;
			nv_ps   <= PS_RST;
			pll_en  <= 1'b1;
			fo      <= FO_RST;
			tst     <= TT_IDLE;
			edge_ns <= 30'h0;
			cnt     <= 16'h0000;
			seen    <= 1'b0;
			s       <= 34'sh0;
			tag     <= 30'h0;
			tag_ok  <= 1'b0;
		end else begin
			ns_now  <= next_ns_now;
			div     <= next_div;
			pos     <= next_pos;
			mod_r   <= next_mod_r;
			mod_k   <= next_mod_k;
			busy    <= next_busy;
			plc     <= next_plc;
			pw_cnt  <= next_pw_cnt;
			pps_q   <= next_pps_q;
			dac     <= next_dac;
			ts      <= next_ts;
			to      <= next_to;
			ps      <= next_ps;
			nv_ts   <= next_nv_ts;
			nv_to   <= next_nv_to;
			nv_ps   <= next_nv_ps;
			pll_en  <= next_pll_en;
			fo      <= next_fo;
			tst     <= next_tst;
			edge_ns <= next_edge_ns;
			cnt     <= next_cnt;
			seen    <= next_seen;
			s       <= next_s;
			tag     <= next_tag;
			tag_ok  <= next_tag_ok;
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_tag_range: assert property (tag_ok |-> tag < 30'(SEC_LEN))
		else $error("tag out of range");
	chk_none_read: assert property (rd && paddr == A_TAG && !tag_ok |-> prdata == TAG_NONE)
		else $error("missing tag not read as minus one");
	chk_read_clears: assert property (rd && paddr == A_TAG && !done |=> !tag_ok)
		else $error("tag still valid after read");
	chk_done_sets: assert property (done |=> tag_ok && tag == 30'($past(s)))
		else $error("result not posted");
	chk_ts_limits: assert property (ts >= TS_MIN && ts <= TS_MAX)
		else $error("time slope out of range");
	chk_ps_limits: assert property (ps >= PS_MIN && ($past(busy) || dac <= $past(ps)))
		else $error("pulse slope or dac out of range");
	chk_to_limits: assert property (signed'(to) >= TO_MIN && signed'(to) <= TO_MAX)
		else $error("offset out of range");
	chk_fo_limit: assert property (signed'(fo) >= -FO_LIM && signed'(fo) <= FO_LIM)
		else $error("frequency offset out of range");
	chk_fire_width: assert property (fire |=> pps_out [*8])
		else $error("output pulse too short");
	chk_pp_busy: assert property (wr && paddr == A_PP && !busy && pwdata < SEC_LEN
		|=> busy ##24 !busy)
		else $error("placement split not finished in time");
	chk_restart_load: assert property (wr && paddr == A_CTRL && pwdata[C_RESTART]
		|=> ts == $past(nv_ts) && ps == $past(nv_ps))
		else $error("restart did not load stored values");
	chk_store_ts: assert property (wr && paddr == A_CTRL && pwdata[C_ST_TS]
		|=> nv_ts == $past(ts))
		else $error("store did not save time slope");

	cov_tag_done: cover property (done);
	cov_tag_wrap: cover property (tst == TT_NORM && s < 0);
	cov_pp_move: cover property (wr && paddr == A_PP && !busy);
	cov_restart: cover property (wr && paddr == A_CTRL && pwdata[C_RESTART]);
endmodule
`default_nettype wire

// >>> tb/ppt_pps_src.sv
// Purpose: external 1pps source with the analog stretcher stand-in
// Assumes: period given in clk cycles, a multiple of the 2.5 MHz tick
// Notes: free-running, same reset and second as the block, so fixed in phase to the block's own time count
`timescale 1ns/1ns
`default_nettype none
module ppt_pps_src #(
	parameter int PERIOD_CYC = 1000,
	parameter int PULSE_CYC  = 50,
	parameter int STR_START  = 10,
	parameter int STR_CYC    = 100
) (
	input  wire logic clk,
	input  wire logic rst_n,
	output logic      pps_in,
	output logic      stretch_in
);
	int phase;
	// position within the source's own second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= 0;
		end else begin
			phase <= (phase == PERIOD_CYC - 1) ? 0 : phase + 1;
		end
	end
	// one pulse per period, low in between
	assign pps_in = rst_n && (phase < PULSE_CYC);
	// stretched gap
	// fixed length, so every second yields the same count
	assign stretch_in = rst_n && (phase >= STR_START) && (phase < STR_START + STR_CYC);
endmodule
`default_nettype wire

// >>> tb/ppt_core_test.sv
// Purpose: self-checking bench for the placement and time-tag block
// Assumes: shortened second of 20000 ns, pll switched off for tag tests
// Notes: tags are checked as differences, so sync latency cancels
`timescale 1ns/1ns
`default_nettype none
module ppt_core_test;
	import ppt_pkg::*;
	localparam int unsigned SEC_SIM = 20000;
	logic        clk, rst_n, psel, penable, pwrite;
	logic        pready, pslverr, pps_in, stretch_in, pps_out;
	logic        e;
	logic [7:0]  paddr, dac;
	logic [31:0] pwdata, prdata, q, t0, t1, x;
	int          bad_count, compares, n;

	ppt_core #(.SEC_LEN(SEC_SIM)) DUT (.clk(clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pps_in(pps_in),
		.stretch_in(stretch_in), .pps_out(pps_out), .fine_delay_dac_code(dac));
	ppt_pps_src #(.PERIOD_CYC(SEC_SIM / CLK_NS)) src (.clk(clk), .rst_n(rst_n),
		.pps_in(pps_in), .stretch_in(stretch_in));

	// clock, 20 ns period
	always #10 clk = ~clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
			bad_count++;
		end
	endtask
	// one apb transfer, called just after a rising edge; result left in q and e
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		// answer taken at the edge where pready is seen high
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			bad_count++;
			print_verdict();
		end
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000);
		chk(q, exp);
	endtask
	task automatic wrchk(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
		apb(1'b1, a, d);
		rd(a, exp);
	endtask
	// skip one possibly stale tag, return the next fresh one
	task automatic get_tag(output logic [31:0] t);
		for (int i = 0; i < 2; i++) begin
			n = 0;
			do begin
				apb(1'b0, A_STAT, 32'h00000000);
				n++;
			end while (q[0] !== 1'b1 && n < 1000);
			if (n >= 1000) begin
				bad_count++;
				print_verdict();
			end
			apb(1'b0, A_TAG, 32'h00000000);
		end
		t = q;
	endtask
	task automatic until_out(input logic v);
		while (pps_out !== v && n < 3000) begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// watchdog well beyond the expected run
	initial begin
		repeat (80000) @(posedge clk);
		$display("watchdog expired");
		bad_count++;
		print_verdict();
	end

	// main sequence
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		bad_count = 0;
		compares = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(A_TAG, 32'hFFFFFFFF);
		rd(A_STAT, 32'h00000004);
		rd(A_TS, 32'h00003333);
		rd(A_TO, 32'h00000000);
		rd(A_PS, 32'h000000C8);
		rd(A_NV_TS, 32'h00003333);
		rd(A_POS, 32'h00000000);
		apb(1'b0, 8'h30, 32'h00000000);
		chk({31'h0, e}, 32'h00000001);
		$display("test reset_values done");
		// output pulse width and period
		n = 0;
		until_out(1'b0);
		until_out(1'b1);
		n = 0;
		until_out(1'b0);
		chk(32'(n), PULSE_W_CYC);
		until_out(1'b1);
		chk(32'(n), SEC_SIM / CLK_NS);
		$display("test pulse_train done");
		apb(1'b1, A_CTRL, 32'h00000000);
		// bench acts as the factory station here
		wrchk(A_TS, 32'h00001B57, 32'h00003333);
		wrchk(A_TS, 32'h00001B58, 32'h00001B58);
		wrchk(A_TS, 32'h000061A9, 32'h00001B58);
		wrchk(A_TS, 32'h000061A8, 32'h000061A8);
		wrchk(A_PS, 32'h00000063, 32'h000000C8);
		wrchk(A_PS, 32'h00000064, 32'h00000064);
		wrchk(A_PS, 32'h000000FF, 32'h000000FF);
		wrchk(A_TO, 32'hFFFF8000, 32'h00000000);
		wrchk(A_TO, 32'hFFFF8001, 32'hFFFF8001);
		wrchk(A_TO, 32'h00008000, 32'h00008000);
		apb(1'b1, A_CTRL, 32'h00000007);
		rd(A_NV_TO, 32'h00008000);
		rd(A_NV_PS, 32'h000000FF);
		rd(A_NV_TS, 32'h000061A8);
		wrchk(A_TO, 32'h00000007, 32'h00000007);
		rd(A_NV_TO, 32'h00008000);
		apb(1'b1, A_CTRL, 32'h00000008);
		rd(A_TO, 32'h00008000);
		rd(A_TS, 32'h000061A8);
		rd(A_PS, 32'h000000FF);
		apb(1'b1, A_CTRL, 32'h00000000);
		apb(1'b1, A_TO, 32'h00000000);
		apb(1'b1, A_PS, 32'h000000C8);
		apb(1'b1, A_TS, 32'h00003333);
		$display("test limits_store done");
		get_tag(t0);
		chk(32'(t0 < SEC_SIM), 32'h00000001);
		rd(A_TAG, 32'hFFFFFFFF);
		apb(1'b1, A_TO, 32'h000003E8);
		get_tag(t1);
		chk(t1, (t0 + 32'h000003E8) % SEC_SIM);
		// loopback calibration, deliberately 1 ns short
		apb(1'b1, A_TO, 32'h000003E7 - t1);
		get_tag(x);
		chk(x, SEC_SIM - 1);
		$display("test timetag done");
		apb(1'b1, A_PP, 32'h0000015E);
		chk({31'h0, e}, 32'h00000000);
		apb(1'b1, A_PP, 32'h0000015E);
		chk({31'h0, e}, 32'h00000001);
		rd(A_POS, SEC_SIM - 32'h0000015E);
		get_tag(t1);
		chk(t1, 32'h0000015D);
		chk(32'((dac >= 8'h63) && (dac <= 8'h65)), 32'h00000001);
		$display("test place_pulse done");
		print_verdict();
	end
endmodule
`default_nettype wire
